/* dv/pin_model.sv */
// pin side model: pull-ups and an external driver
`timescale 1ns/1ps
`default_nettype none
module pin_model (
   input wire logic [31:0] line_out,
   input wire logic [31:0] line_oe,
   input wire logic [31:0] ext_oe,
   input wire logic [31:0] ext_val,
   output logic [31:0] line_in
);
   assign line_in = (line_oe & line_out) | (~line_oe & ext_oe & ext_val) | (~line_oe & ~ext_oe);
endmodule : pin_model
`default_nettype wire

/* dv/quad_port_digital_io_tb.sv */
// self-checking bench for the quad digital i/o port
`timescale 1ns/1ps
`default_nettype none
module quad_port_digital_io_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] ext_oe = 32'h0;
   logic [31:0] ext_val = 32'h0;
   logic [31:0] prdata, line_in, line_out, line_oe;
   logic pready, pslverr, irq, event_irq, err;
   logic [7:0] rd;
   int n_fail = 0;
   int comparisons = 0;

   // clock
   always #5 pclk = ~pclk;

   quad_port_digital_io u_quad_port_digital_io (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_in(line_in),
      .line_out(line_out), .line_oe(line_oe), .irq(irq), .event_irq(event_irq));

   pin_model u_pin_model (.line_out(line_out), .line_oe(line_oe), .ext_oe(ext_oe),
      .ext_val(ext_val), .line_in(line_in));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {26'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h0, 32'h1, "no pready");
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rchk(input logic [3:0] idx, input logic [7:0] exp, input string m);
      apb(1'b0, idx, 8'h00);
      chk({24'h0, rd}, {24'h0, exp}, m);
   endtask : rchk

   task automatic t_reset;
      rchk(4'h4, 8'h00, "direction");
      rchk(4'h5, 8'h00, "int ctrl");
      chk(line_oe, 32'h0, "oe at reset");
      $display("test reset done");
   endtask : t_reset

   task automatic t_input;
      ext_oe <= 32'h00FF00FF;
      ext_val <= 32'h003C005A;
      wt(4);
      rchk(4'h0, 8'h5A, "port a in");
      rchk(4'h2, 8'h3C, "port c in");
      rchk(4'h1, 8'hFF, "port b pulled");
      rchk(4'h3, 8'hFF, "port d pulled");
      chk({31'h0, irq}, 32'h0, "irq masked");
      rchk(4'h5, 8'h40, "low level pending");
      $display("test input done");
   endtask : t_input

   task automatic t_output;
      ext_oe <= 32'h0;
      for (int p = 0; p < 4; p++) apb(1'b1, p[3:0], 8'hA5 ^ p[7:0]);
      chk(line_oe, 32'h0, "oe while input");
      rchk(4'h1, 8'hFF, "input reads pin");
      apb(1'b1, 4'h4, 8'h0A);
      wt(2);
      chk(line_oe, 32'hFF00FF00, "oe b d");
      chk(line_out & line_oe, 32'hA600A400, "drive b d");
      rchk(4'h1, 8'hA4, "output readback");
      apb(1'b1, 4'h4, 8'h0F);
      wt(2);
      chk(line_out, 32'hA6A7A4A5, "kept values");
      apb(1'b1, 4'h4, 8'h00);
      $display("test output done");
   endtask : t_output

   task automatic t_irq;
      logic [1:0] m;
      ext_oe <= 32'h1;
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         ext_val[0] <= ~m[0];
         apb(1'b1, 4'h5, {6'h0, m});
         wt(6);
         apb(1'b0, 4'h5, 8'h00);
         apb(1'b1, 4'h5, {6'h20, m});
         wt(6);
         chk({31'h0, irq}, 32'h0, "irq quiet");
         ext_val[0] <= m[0];
         wt(6);
         chk({31'h0, irq}, 32'h1, "irq raised");
         rchk(4'h5, {6'h30, m}, "pending");
         wt(2);
         if (!m[1]) begin
            rchk(4'h5, {6'h30, m}, "level holds");
            ext_val[0] <= ~m[0];
            wt(6);
            apb(1'b0, 4'h5, 8'h00);
         end
         wt(2);
         rchk(4'h5, {6'h20, m}, "cleared");
         chk({31'h0, irq}, 32'h0, "irq low");
      end
      $display("test irq done");
   endtask : t_irq

   task automatic t_events;
      apb(1'b1, 4'h9, 8'h03);
      apb(1'b1, 4'hA, 8'h00);
      apb(1'b1, 4'h2, 8'h11);
      rchk(4'h8, 8'h02, "write event");
      chk({31'h0, event_irq}, 32'h0, "event masked");
      apb(1'b1, 4'hA, 8'h02);
      wt(3);
      chk({31'h0, event_irq}, 32'h1, "event irq");
      apb(1'b1, 4'h9, 8'h02);
      wt(3);
      chk({31'h0, event_irq}, 32'h0, "event cleared");
      rchk(4'h8, 8'h00, "status clear");
      $display("test events done");
   endtask : t_events

   task automatic t_map;
      apb(1'b1, 4'h6, 8'hFF);
      rchk(4'h6, 8'h00, "read zero a");
      rchk(4'h7, 8'h00, "read zero b");
      apb(1'b0, 4'hB, 8'h00);
      chk({31'h0, err}, 32'h1, "unmapped err");
      chk({24'h0, rd}, 32'h0, "unmapped data");
      $display("test map done");
   endtask : t_map

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   // main sequence
   initial begin
      wt(2);
      presetn <= 1'b1;
      wt(1);
      t_reset();
      t_input();
      t_output();
      t_irq();
      t_events();
      t_map();
      end_of_test();
   end

   // watchdog
   initial begin
      wt(20000);
      n_fail++;
      end_of_test();
   end
endmodule : quad_port_digital_io_tb
`default_nettype wire

/* inc/quad_port_digital_io_pkg.sv */
// package: register map, fields and reset values of the quad digital i/o port
package quad_port_digital_io_pkg;
   localparam int unsigned port_count = 4;
   localparam int unsigned port_width = 8;
   // register indices (byte offsets as printed), byte address is four times the index
   localparam logic [2:0] idx_port_a_data = 3'h0;
   localparam logic [2:0] idx_port_b_data = 3'h1;
   localparam logic [2:0] idx_port_c_data = 3'h2;
   localparam logic [2:0] idx_port_d_data = 3'h3;
   localparam logic [2:0] idx_port_direction = 3'h4;
   localparam logic [2:0] idx_interrupt_control_status = 3'h5;
   localparam logic [2:0] idx_unused_read_zero_a = 3'h6;
   localparam logic [2:0] idx_unused_read_zero_b = 3'h7;
   // extra interrupt registers, word indices
   localparam logic [3:0] idx_event_status = 4'h8;
   localparam logic [3:0] idx_event_clear = 4'h9;
   localparam logic [3:0] idx_event_enable = 4'hA;
   localparam int unsigned addr_lsb = 2;
   localparam int unsigned addr_bits = 4;
   // fields of interrupt_control_status
   localparam int unsigned trigger_mode_low_bit = 0;
   localparam int unsigned trigger_mode_high_bit = 1;
   localparam int unsigned interrupt_pending_bit = 6;
   localparam int unsigned interrupt_enable_bit = 7;
   // event status bit positions
   localparam int unsigned evt_trigger = 0;
   localparam int unsigned evt_output_write = 1;
   localparam int unsigned event_count = 2;
   // reset values
   localparam logic [7:0] data_reset = 8'h00;
   localparam logic [3:0] direction_reset = 4'h0;
   localparam logic [1:0] mode_reset = 2'h0;
   localparam logic [event_count-1:0] event_reset = 2'h0;
   typedef enum logic [1:0] {
      mode_low_level,
      mode_high_level,
      mode_falling_edge,
      mode_rising_edge
   } trigger_mode_t;
   // apb request carrier
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } apb_req_t;
endpackage : quad_port_digital_io_pkg

/* rtl/quad_port_digital_io.sv */
// quad eight-bit digital i/o port with apb register slave, one pin interrupt source and an event interrupt
// Function
// - input lines read back without inversion
// - undriven inputs read one via pull-ups
// - output port reads its output register
// - output register kept in either direction
// - output bit one drives high, zero low
// - direction bits 0..3 ports a..d, one=output
// - reset makes every port an input
// - port data registers at offsets zero..three
// - port a bit zero is interrupt source
// - mode field selects level or edge trigger
// - enable bit seven gates interrupt, reset clear
// - pending bit six clears on host read
// - level pending holds until source changes
// - each port is one byte in the word at base plus four times n
`timescale 1ns/1ps
`default_nettype none
module quad_port_digital_io #(
   parameter int unsigned ports = 4,
   parameter int unsigned width = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] line_in,
   output logic [31:0] line_out,
   output logic [31:0] line_oe,
   output logic irq,
   output logic event_irq
);
   // elaboration check on the structural parameters
   if (ports != quad_port_digital_io_pkg::port_count ||
       width != quad_port_digital_io_pkg::port_width) begin : g_bad_params
      $error("quad_port_digital_io supports only four eight-bit ports");
   end

   quad_port_digital_io_pkg::apb_req_t req;
   logic [7:0] out_q [4];
   logic [3:0] dir_q;
   logic [1:0] mode_q;
   logic irq_en_q;
   logic pend_q;
   logic [1:0] sync_q;
   logic src_prev_q;
   logic [1:0] evt_q;
   logic [1:0] evt_en_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic irq_q;
   logic event_irq_q;
   logic [31:0] line_out_q;
   logic [31:0] line_oe_q;
   logic [3:0] widx;
   logic access;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic trig;
   logic rd_clear;
   logic [7:0] rd_byte;
   logic [31:0] rd_word;
   logic src;

   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   assign widx = req.addr[quad_port_digital_io_pkg::addr_lsb +: 4];
   assign access = req.sel && req.enable && !pready_q;
   assign mapped = (req.addr[31:6] == 26'h0000000) && (widx <= quad_port_digital_io_pkg::idx_event_enable);
   assign wr_acc = access && req.write && mapped && pstrb[0];
   assign rd_acc = access && !req.write && mapped;
   assign src = sync_q[1];

   // value of a port as seen by a read: input pins or output register
   function automatic logic [7:0] port_view(input logic dir, input logic [7:0] q,
                                            input logic [7:0] pins);
      port_view = dir ? q : pins;
   endfunction : port_view

   // apb handshake: one wait state, answer in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= access;
         pslverr_q <= access && !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            out_q[i] <= quad_port_digital_io_pkg::data_reset;
         end
      end else if (wr_acc && widx <= 4'(quad_port_digital_io_pkg::idx_port_d_data)) begin
         out_q[widx[1:0]] <= req.wdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= quad_port_digital_io_pkg::direction_reset;
      end else if (wr_acc && widx == 4'(quad_port_digital_io_pkg::idx_port_direction)) begin
         dir_q <= req.wdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= quad_port_digital_io_pkg::mode_reset;
         irq_en_q <= 1'b0;
      end else if (wr_acc && widx == 4'(quad_port_digital_io_pkg::idx_interrupt_control_status)) begin
         mode_q <= req.wdata[quad_port_digital_io_pkg::trigger_mode_high_bit:
                             quad_port_digital_io_pkg::trigger_mode_low_bit];
         irq_en_q <= req.wdata[quad_port_digital_io_pkg::interrupt_enable_bit];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q <= 2'h3;
         src_prev_q <= 1'b1;
      end else begin
         sync_q <= {sync_q[0], line_in[0]};
         src_prev_q <= src;
      end
   end

   always_comb begin
      case (quad_port_digital_io_pkg::trigger_mode_t'(mode_q))
         quad_port_digital_io_pkg::mode_low_level: trig = !src;
         quad_port_digital_io_pkg::mode_high_level: trig = src;
         quad_port_digital_io_pkg::mode_falling_edge: trig = src_prev_q && !src;
         quad_port_digital_io_pkg::mode_rising_edge: trig = !src_prev_q && src;
         default: trig = 1'b0;
      endcase
   end

   assign rd_clear = rd_acc && widx == 4'(quad_port_digital_io_pkg::idx_interrupt_control_status);

   // level keeps pending until source changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
      end else if (trig) begin
         pend_q <= 1'b1;
      end else if (rd_clear) begin
         pend_q <= 1'b0;
      end
   end

   // sticky event status, clear register, enable register; set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_q <= quad_port_digital_io_pkg::event_reset;
         evt_en_q <= quad_port_digital_io_pkg::event_reset;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == quad_port_digital_io_pkg::evt_trigger && trig) ||
                (i == quad_port_digital_io_pkg::evt_output_write && wr_acc &&
                 widx <= 4'(quad_port_digital_io_pkg::idx_port_d_data))) begin
               evt_q[i] <= 1'b1;
            end else if (wr_acc && widx == quad_port_digital_io_pkg::idx_event_clear && req.wdata[i]) begin
               evt_q[i] <= 1'b0;
            end
         end
         if (wr_acc && widx == quad_port_digital_io_pkg::idx_event_enable) begin
            evt_en_q <= req.wdata[1:0];
         end
      end
   end

   // read data mux
   always_comb begin
      rd_byte = 8'h00;
      rd_word = 32'h0000_0000;
      if (widx <= 4'(quad_port_digital_io_pkg::idx_port_d_data)) begin
         rd_byte = port_view(dir_q[widx[1:0]], out_q[widx[1:0]], line_in[8*widx[1:0] +: 8]);
      end else if (widx == 4'(quad_port_digital_io_pkg::idx_port_direction)) begin
         rd_byte = {4'h0, dir_q};
      end else if (widx == 4'(quad_port_digital_io_pkg::idx_interrupt_control_status)) begin
         rd_byte = {irq_en_q, pend_q, 4'h0, mode_q};
      end else if (widx == quad_port_digital_io_pkg::idx_event_status) begin
         rd_byte = {6'h00, evt_q};
      end else if (widx == quad_port_digital_io_pkg::idx_event_enable) begin
         rd_byte = {6'h00, evt_en_q};
      end
      rd_word = {24'h000000, rd_byte};
   end

   // read data register, captured with the answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (access) begin
         prdata_q <= rd_acc ? rd_word : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_out_q <= 32'h0000_0000;
         line_oe_q <= 32'h0000_0000;
      end else begin
         for (int i = 0; i < 4; i++) begin
            line_out_q[8*i +: 8] <= out_q[i];
            line_oe_q[8*i +: 8] <= {8{dir_q[i]}};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
         event_irq_q <= 1'b0;
      end else begin
         irq_q <= pend_q && irq_en_q;
         event_irq_q <= |(evt_q & evt_en_q);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign line_out = line_out_q;
   assign line_oe = line_oe_q;
   assign irq = irq_q;
   assign event_irq = event_irq_q;

   // interrupt pending and enabled together
   sequence s_pend_on;
      pend_q && irq_en_q;
   endsequence

   // host write to the direction register
   sequence s_dir_write;
      wr_acc && widx == 4'(quad_port_digital_io_pkg::idx_port_direction);
   endsequence

   // host write to the interrupt control register
   sequence s_ctrl_write;
      wr_acc && widx == 4'(quad_port_digital_io_pkg::idx_interrupt_control_status);
   endsequence

   // host write to the port a data register
   sequence s_porta_write;
      wr_acc && widx == 4'(quad_port_digital_io_pkg::idx_port_a_data);
   endsequence

   // host read of the interrupt control register
   sequence s_ctrl_read;
      rd_acc && widx == 4'(quad_port_digital_io_pkg::idx_interrupt_control_status);
   endsequence

   // interrupt output checks
   // irq follows pending
   chk_irq_follow: assert property (@(posedge pclk) disable iff (!presetn)
      s_pend_on |=> irq) else $error("irq not raised for pending enabled interrupt");
   chk_irq_no_pend: assert property (@(posedge pclk) disable iff (!presetn)
      !pend_q |=> !irq) else $error("irq raised with nothing pending");
   chk_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
      !irq_en_q |=> !irq) else $error("irq raised while disabled");
   chk_en_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_ctrl_write |=> irq_en_q == $past(req.wdata[7])) else $error("enable bit not written");

   // direction and pin checks
   // inputs after reset
   chk_dir_reset: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> dir_q == 4'h0) else $error("direction not cleared");
   chk_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_dir_write |=> dir_q == $past(req.wdata[3:0])) else $error("direction not written");
   chk_out_drive: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 line_out[7:0] == $past(out_q[0])) else $error("port a pins not driven from register");
   chk_oe_dir: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 line_oe[31:24] == {8{$past(dir_q[3])}}) else $error("port d enable wrong");
   chk_oe_port_a: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 line_oe[7:0] == {8{$past(dir_q[0])}}) else $error("port a enable wrong");

   // data register checks
   // port a write lands
   chk_data_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_porta_write |=> out_q[0] == $past(req.wdata[7:0])) else $error("port a not written");
   chk_data_keep: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_acc && widx == 4'h0) |=> out_q[0] == $past(out_q[0])) else $error("port a changed");
   chk_in_read: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_acc && widx == 4'h0 && !dir_q[0]) |=> prdata[7:0] == $past(line_in[7:0]))
      else $error("port a input read wrong");
   chk_out_read: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_acc && widx == 4'h1 && dir_q[1]) |=> prdata[7:0] == $past(out_q[1]))
      else $error("port b output read wrong");
   chk_zero_reg: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_acc && widx == 4'h6) |=> prdata == 32'h0000_0000) else $error("spare not zero");

   // trigger and pending checks
   // mode field written
   chk_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
      s_ctrl_write |=> mode_q == $past(req.wdata[1:0])) else $error("mode not written");
   chk_rise_set: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == 2'h3 && !src_prev_q && src) |=> pend_q) else $error("rising edge missed");
   chk_fall_set: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == 2'h2 && src_prev_q && !src) |=> pend_q) else $error("falling edge missed");
   chk_high_set: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == 2'h1 && src) |=> pend_q) else $error("high level missed");
   chk_low_set: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == 2'h0 && !src) |=> pend_q) else $error("low level missed");
   chk_pend_source: assert property (@(posedge pclk) disable iff (!presetn)
      (!pend_q && !trig) |=> !pend_q) else $error("pending set without source");
   chk_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_clear && !trig) |=> !pend_q) else $error("pending not cleared by read");
   chk_pend_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (pend_q && !rd_clear) |=> pend_q) else $error("pending lost without read");
   chk_pend_read: assert property (@(posedge pclk) disable iff (!presetn)
      s_ctrl_read |=> prdata[6] == $past(pend_q)) else $error("pending bit read wrong");
   chk_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_q == 2'h0 && !src && rd_clear) |=> pend_q) else $error("low level pending lost");

   // synchroniser checks
   // two-cycle source delay
   chk_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
      ##2 src == $past(line_in[0], 2)) else $error("source sync delay wrong");
   chk_edge_prev: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 src_prev_q == $past(src)) else $error("edge reference wrong");

   // bus answer checks
   // one-cycle ready pulse
   chk_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready held two cycles");
   chk_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
      access |=> pready) else $error("access not answered");
   chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !mapped) |=> pslverr) else $error("unmapped access without error");
   chk_err_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready) else $error("pslverr without pready");
endmodule : quad_port_digital_io
`default_nettype wire
